/* File: src/spcb_top.v */
// Summary of operation
// - with status view off, top two control bits pick the frame mode
// - framing error flag in bit 7, set by hardware, cleared by software
// - overrun flag in bit 6, set by hardware, cleared by software
// - synchronous mode shifts at clock/12, or clock/4 with select set
// - eight-bit async with select set: only high stop bit raises receive-done
// - nine-bit modes with select set: only ninth bit one raises receive-done
// - collision flag in bit 5, visible with status view, software clears
// - receiver enable in bit 4 gates reception
// - nine-bit modes send the software ninth bit as ninth data bit
// - received ninth bit: unused sync, stop bit async8, ninth bit async9
// - transmit-done set as the last frame bit starts on the line, cleared only by software
// - receive-done set when reception completes, cleared only by software
// - data buffer write while the transmitter is idle loads the transmit shifter and starts sending
// - data buffer read returns the separate receive latch
// - status view select in power control swaps top bits to error flags
`timescale 1ns/100ps
`include "spcb_defines.vh"
module spcb_top (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire rx_line,
  output wire tx_line,
  output wire serial_irq,
  output wire irq
);
  reg [1:0] mode_q;
  reg mps_q;
  reg fe_q;
  reg ov_q;
  reg col_q;
  reg ren_q;
  reg tb8_q;
  reg rb8_q;
  reg ti_q;
  reg ri_q;
  reg statview_q;
  reg [7:0] pwr_q;
  reg [7:0] rxbuf_q;
  reg rxunread_q;
  reg [15:0] baud_q;
  reg [4:0] ist_q;
  reg [4:0] imask_q;
  // receive machine
  localparam RX_IDLE = 2'd0;
  localparam RX_BITS = 2'd1;
  localparam RX_STOP = 2'd2;
  reg [1:0] rst_q;
  reg [15:0] rcnt_q;
  reg [3:0] ridx_q;
  reg [8:0] rsh_q;
  reg rx_prev_q;

  function sel;
    input [7:0] a;
    input [7:0] ref_a;
    begin
      sel = (a == ref_a);
    end
  endfunction

  wire nine = mode_q[1];
  wire wr_ctrl = wr && sel(addr, `SPCB_ADDR_CTRL);
  wire wr_data = wr && sel(addr, `SPCB_ADDR_DATA);
  wire rd_data = rd && sel(addr, `SPCB_ADDR_DATA);

  // bit rate
  reg [15:0] div;
  always @* begin
    case (mode_q)
      2'b00: div = mps_q ? `SPCB_SYNC_DIV_FAST : `SPCB_SYNC_DIV_SLOW;
      2'b10: div = `SPCB_FIXED_DIV;
      default: div = baud_q;
    endcase
  end
  wire tx_busy;
  wire tx_done;
  wire tick;
  spcb_rate u_rate (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .run(1'b1),
    .div(div),
    .tick(tick)
  );
  reg [10:0] frame;
  reg [3:0] nbits;
  always @* begin
    case (mode_q)
      2'b00: begin
        frame = {3'b111, wdata};
        nbits = 4'd8;
      end
      2'b01: begin
        frame = {2'b11, wdata, 1'b0};
        nbits = 4'd10;
      end
      default: begin
        frame = {1'b1, tb8_q, wdata, 1'b0};
        nbits = 4'd11;
      end
    endcase
  end
  spcb_shift u_tx (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .tick(tick),
    .load(wr_data),
    .frame(frame),
    .nbits(nbits),
    .line_o(tx_line),
    .busy(tx_busy),
    .done(tx_done)
  );
  wire col_ev = wr_data && tx_busy;

  // receiver: samples mid-bit using the same divider
  wire [15:0] half = {1'b0, div[15:1]};
  wire rx_fall = rx_prev_q && !rx_line;
  reg rx_done_ev;
  reg rx_ok;
  reg fe_ev;
  always @* begin
    rx_done_ev = 1'b0;
    rx_ok = 1'b0;
    fe_ev = 1'b0;
    if (rst_q == RX_STOP && rcnt_q == 16'h0000) begin
      rx_done_ev = 1'b1;
      fe_ev = !rx_line && mode_q != 2'b00;
      case (mode_q)
        2'b00: rx_ok = 1'b1;
        2'b01: rx_ok = !mps_q || rx_line;
        default: rx_ok = !mps_q || rsh_q[8];
      endcase
    end
  end
  wire ov_ev = rx_done_ev && rx_ok && rxunread_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= RX_IDLE;
      rcnt_q <= 16'h0000;
      ridx_q <= 4'h0;
      rsh_q <= 9'h000;
      rx_prev_q <= 1'b1;
    end else if (ce) begin
      rx_prev_q <= rx_line;
      case (rst_q)
        RX_IDLE: begin
          if (ren_q && rx_fall) begin
            rst_q <= RX_BITS;
            rcnt_q <= div + half;
            ridx_q <= 4'h0;
          end
        end
        RX_BITS: begin
          if (!ren_q) begin
            rst_q <= RX_IDLE;
          end else if (rcnt_q == 16'h0000) begin
            rsh_q <= {rx_line, rsh_q[8:1]};
            ridx_q <= ridx_q + 4'h1;
            rcnt_q <= div - 16'h0001;
            if (ridx_q == (nine ? 4'd8 : 4'd7)) begin
              rst_q <= RX_STOP;
            end
          end else begin
            rcnt_q <= rcnt_q - 16'h0001;
          end
        end
        RX_STOP: begin
          if (rcnt_q == 16'h0000) begin
            rst_q <= RX_IDLE;
          end else begin
            rcnt_q <= rcnt_q - 16'h0001;
          end
        end
        default: rst_q <= RX_IDLE;
      endcase
    end
  end

  // control, status and data registers; hardware set wins over software clear
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 2'b00;
      mps_q <= 1'b0;
      fe_q <= 1'b0;
      ov_q <= 1'b0;
      col_q <= 1'b0;
      ren_q <= 1'b0;
      tb8_q <= 1'b0;
      rb8_q <= 1'b0;
      ti_q <= 1'b0;
      ri_q <= 1'b0;
      pwr_q <= 8'h00;
      statview_q <= 1'b0;
      rxbuf_q <= `SPCB_DATA_RESET;
      rxunread_q <= 1'b0;
      baud_q <= `SPCB_BAUD_RESET;
      ist_q <= 5'h00;
      imask_q <= 5'h00;
    end else if (ce) begin
      if (wr_ctrl) begin
        if (statview_q) begin
          fe_q <= wdata[`SPCB_BIT_FE] | fe_ev;
          ov_q <= wdata[`SPCB_BIT_OV] | ov_ev;
          col_q <= wdata[`SPCB_BIT_COL] | col_ev;
        end else begin
          mode_q <= wdata[`SPCB_BIT_MODE_HI:`SPCB_BIT_MODE_LO];
          mps_q <= wdata[`SPCB_BIT_MPS];
          fe_q <= fe_q | fe_ev;
          ov_q <= ov_q | ov_ev;
          col_q <= col_q | col_ev;
        end
        ren_q <= wdata[`SPCB_BIT_REN];
        tb8_q <= wdata[`SPCB_BIT_TB8];
        rb8_q <= wdata[`SPCB_BIT_RB8];
        ti_q <= wdata[`SPCB_BIT_TI] | tx_done;
        ri_q <= wdata[`SPCB_BIT_RI] | (rx_done_ev && rx_ok);
      end else begin
        fe_q <= fe_q | fe_ev;
        ov_q <= ov_q | ov_ev;
        col_q <= col_q | col_ev;
        ti_q <= ti_q | tx_done;
        ri_q <= ri_q | (rx_done_ev && rx_ok);
      end
      if (rx_done_ev && rx_ok) begin
        rxbuf_q <= nine ? rsh_q[7:0] : (mode_q == 2'b00 ? rsh_q[8:1] : rsh_q[8:1]);
        rxunread_q <= 1'b1;
        if (mode_q == 2'b01) begin
          rb8_q <= rx_line;
        end else if (nine) begin
          rb8_q <= rsh_q[8];
        end
      end else if (rd_data) begin
        rxunread_q <= 1'b0;
      end
      if (wr && sel(addr, `SPCB_ADDR_PWR)) begin
        pwr_q <= wdata;
        statview_q <= wdata[`SPCB_BIT_STATVIEW];
      end
      if (wr && sel(addr, `SPCB_ADDR_BAUD)) begin
        baud_q <= {8'h00, wdata};
      end
      if (wr && sel(addr, `SPCB_ADDR_IRQ_MASK)) begin
        imask_q <= wdata[4:0];
      end
      ist_q <= (ist_q & ~((wr && sel(addr, `SPCB_ADDR_IRQ_STAT)) ? wdata[4:0] : 5'h00))
        | {rx_done_ev && rx_ok, tx_done, col_ev, ov_ev, fe_ev};
    end
  end

  // read port
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (ce) begin
      if (rd) begin
        case (addr)
          `SPCB_ADDR_CTRL: rdata <= {statview_q ? {fe_q, ov_q, col_q} : {mode_q, mps_q},
            ren_q, tb8_q, rb8_q, ti_q, ri_q};
          `SPCB_ADDR_DATA: rdata <= rxbuf_q;
          `SPCB_ADDR_PWR: rdata <= {pwr_q[7], statview_q, 2'b00, pwr_q[3:0]};
          `SPCB_ADDR_IRQ_STAT: rdata <= {3'b000, ist_q};
          `SPCB_ADDR_IRQ_MASK: rdata <= {3'b000, imask_q};
          `SPCB_ADDR_BAUD: rdata <= baud_q[7:0];
          default: rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  assign serial_irq = ti_q | ri_q;
  assign irq = |(ist_q & imask_q);
endmodule

/* File: shared/spcb_defines.vh */
`ifndef SPCB_DEFINES_VH
`define SPCB_DEFINES_VH
`define SPCB_ADDR_CTRL 8'h98
`define SPCB_ADDR_DATA 8'h99
`define SPCB_ADDR_PWR 8'h87
`define SPCB_ADDR_IRQ_STAT 8'ha0
`define SPCB_ADDR_IRQ_MASK 8'ha1
`define SPCB_ADDR_BAUD 8'ha2
`define SPCB_BIT_MODE_HI 7
`define SPCB_BIT_MODE_LO 6
`define SPCB_BIT_FE 7
`define SPCB_BIT_OV 6
`define SPCB_BIT_MPS 5
`define SPCB_BIT_COL 5
`define SPCB_BIT_REN 4
`define SPCB_BIT_TB8 3
`define SPCB_BIT_RB8 2
`define SPCB_BIT_TI 1
`define SPCB_BIT_RI 0
`define SPCB_BIT_STATVIEW 6
`define SPCB_CTRL_RESET 8'h00
`define SPCB_DATA_RESET 8'h00
`define SPCB_SYNC_DIV_SLOW 16'd12
`define SPCB_SYNC_DIV_FAST 16'd4
`define SPCB_FIXED_DIV 16'd32
`define SPCB_BAUD_RESET 16'd16
`define SPCB_IRQ_FE 0
`define SPCB_IRQ_OV 1
`define SPCB_IRQ_COL 2
`define SPCB_IRQ_TI 3
`define SPCB_IRQ_RI 4
`endif

/* File: src/spcb_rate.v */
`timescale 1ns/100ps
module spcb_rate (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire run,
  input wire [15:0] div,
  output reg tick
);
  reg [15:0] cnt_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_q <= 16'h0000;
        tick <= 1'b0;
      end else if (cnt_q + 16'h0001 >= div) begin
        cnt_q <= 16'h0000;
        tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
        tick <= 1'b0;
      end
    end
  end
endmodule

/* File: src/spcb_shift.v */
`timescale 1ns/100ps
module spcb_shift (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire tick,
  input wire load,
  input wire [10:0] frame,
  input wire [3:0] nbits,
  output reg line_o,
  output wire busy,
  output reg done
);
  reg [10:0] sh_q;
  reg [3:0] left_q;
  assign busy = (left_q != 4'h0);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q <= 11'h7ff;
      left_q <= 4'h0;
      line_o <= 1'b1;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (load && !busy) begin
        sh_q <= frame;
        left_q <= nbits;
      end else if (busy && tick) begin
        line_o <= sh_q[0];
        sh_q <= {1'b1, sh_q[10:1]};
        left_q <= left_q - 4'h1;
        done <= (left_q == 4'h1);
      end
    end
  end
endmodule

/* File: tb/spcb_checker.sv */
`timescale 1ns/100ps
module spcb_checker (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire rx_line,
  input wire tx_line,
  input wire serial_irq,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
  a_unmapped_zero: assert property (rd && addr == 8'h55 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_idle: assert property ($rose(arst_n) |-> tx_line)
    else $error("tx line low after reset");
  a_ctrl_echo: assert property (wr && addr == 8'h98 ##2 rd && addr == 8'h98
    |=> rdata[4:3] == $past(wdata[4:3], 3)) else $error("control bits lost");
  a_tx_start: assert property (wr && addr == 8'h99 |-> ##[1:40] !tx_line)
    else $error("no start bit");
  a_stop_high: assert property ($rose(serial_irq) && !$past(wr) && !$past(wr, 2)
    |-> tx_line) else $error("done before stop bit");
  a_done_clear: assert property (wr && addr == 8'h98 && wdata[1:0] == 2'b00
    |-> ##2 !serial_irq) else $error("serial irq stuck");
  a_mask_quiet: assert property (wr && addr == 8'ha1 && wdata == 8'h00 |-> ##2 !irq)
    else $error("masked irq high");
endmodule
bind spcb_top spcb_checker i_chk (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_line(rx_line), .tx_line(tx_line),
  .serial_irq(serial_irq), .irq(irq));

/* File: tb/spcb_node.sv */
`timescale 1ns/100ps
module spcb_node (
  input wire clk,
  input wire tx_line,
  output logic rx_line
);
  logic [10:0] got = 11'h000;
  initial rx_line = 1'b1;
  // frame: start, 8 data lsb first, ninth bit, stop
  task automatic send(input logic [8:0] v, input logic stp);
    logic [10:0] f;
    f = {stp, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (32) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask
  always begin
    @(negedge tx_line);
    repeat (16) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      got = {tx_line, got[10:1]};
      if (i < 10) repeat (32) @(posedge clk);
    end
  end
endmodule

/* File: tb/test_spcb_top.sv */
`timescale 1ns/100ps
module test_spcb_top;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rs = 8'h3a, c;
  wire [7:0] rdata;
  wire rx_line, tx_line, serial_irq, irq;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  int q[$];
  spcb_top i_spcb_top (.clk(clk), .arst_n(arst_n), .ce(1'b1), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_line(rx_line), .tx_line(tx_line),
    .serial_irq(serial_irq), .irq(irq));
  spcb_node i_spcb_node (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
  initial forever #2 clk = ~clk;
  function automatic [7:0] lf(input [7:0] s);
    lf = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input [7:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic r(input [7:0] a, input [7:0] m, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata & m);
  endtask
  task automatic wi;
    for (int i = 0; i < 800 && serial_irq !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    r(8'h98, 8'hff, 8'h00);
    r(8'h99, 8'hff, 8'h00);
    r(8'h55, 8'hff, 8'h00);
    w(8'ha1, 8'h18);
    w(8'ha2, 8'h20);
    for (int k = 0; k < 4; k++) begin
      rs = lf(rs);
      c = {1'b1, k[1], 2'b01, k[0], 3'b000};
      w(8'h98, c);
      r(8'h98, 8'hf8, c);
      w(8'h99, rs);
      q.push_back({k[0], rs});
      if (k == 3) w(8'h99, ~rs);
      wi();
      chk("serial_irq", 1, serial_irq);
      chk("irq", 1, irq);
      repeat (24) @(posedge clk);
      chk("frame", q.pop_front(), i_spcb_node.got[9:1]);
      chk("stop", 1, i_spcb_node.got[10]);
      w(8'ha0, 8'h1f);
      w(8'h98, c);
    end
    w(8'h87, 8'h40);
    r(8'h98, 8'he0, 8'h20);
    w(8'h98, 8'h10);
    r(8'h98, 8'he0, 8'h00);
    w(8'h87, 8'h00);
    for (int j = 0; j < 5; j++) begin
      c = {2'b10, j[1], j < 4, 4'b0000};
      w(8'h98, c);
      rs = lf(rs);
      i_spcb_node.send({j[0], rs}, 1'b1);
      repeat (40) @(posedge clk);
      chk("rx_done", (!j[1] || j[0]) && j < 4, serial_irq);
      if (serial_irq === 1'b1) begin
        r(8'h99, 8'hff, rs);
        r(8'h98, 8'h04, {5'b0, j[0], 2'b0});
      end
      w(8'ha0, 8'h1f);
      w(8'h98, c);
    end
    w(8'h98, 8'h90);
    i_spcb_node.send(9'h0c3, 1'b1);
    rs = lf(rs);
    i_spcb_node.send({1'b0, rs}, 1'b1);
    r(8'h99, 8'hff, rs);
    i_spcb_node.send(9'h03c, 1'b0);
    repeat (40) @(posedge clk);
    w(8'h87, 8'h40);
    r(8'h98, 8'he0, 8'hc0);
    w(8'h98, 8'h10);
    r(8'h98, 8'he0, 8'h00);
    w(8'ha1, 8'h00);
    repeat (3) @(posedge clk);
    chk("irq_masked", 0, irq);
    stop_test;
  end
endmodule
